// ===== rtl/adc_cfg_ctrl.sv
// Configuration, channel selection and APB registers of the converter.

////////////////////////////////////////////////////////////////////////////
module adc_cfg_ctrl #(
  parameter int SETTLE_CYCLES = adc_cfg_pkg::SETTLE_CYCLES,
  parameter int SEQ_LEN = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic range_strap_lo_in,
  input wire logic range_strap_hi_in,
  input wire logic reference_source_pin_in,
  input wire logic [2:0] pair_select_pins_in,
  input wire logic conv_start_in,
  input wire logic signed [adc_cfg_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic sw_mode_out,
  output logic int_ref_en_out,
  output logic cfg_ready_out,
  output logic [3:0] conv_a_sel_out,
  output logic [3:0] conv_b_sel_out,
  output logic [1:0] range_a_out,
  output logic [1:0] range_b_out,
  output logic settling_out,
  output logic [adc_cfg_pkg::CODE_W-1:0] result_out,
  output logic result_valid_out
);
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam int PTR_W = $clog2(SEQ_LEN);

  ////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic seq_en;
    logic [PTR_W-1:0] seq_last;
    logic [3:0] man_a;
    logic [3:0] man_b;
    logic [31:0] ranges;
    logic [SEQ_LEN*8-1:0] seq;
    logic [PTR_W-1:0] seq_ptr;
    logic [1:0] hw_range;
    logic [CNT_W-1:0] settle_cnt;
    logic settling;
    logic [3:0] sel_a;
    logic [3:0] sel_b;
    logic [1:0] range_a;
    logic [1:0] range_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctrl_t;

  localparam ctrl_t CTRL_STATE_RST = '{
    seq_en: adc_cfg_pkg::CTRL_RST[adc_cfg_pkg::CTRL_SEQ_EN_BIT],
    seq_last: '0,
    man_a: '0,
    man_b: '0,
    ranges: adc_cfg_pkg::RANGE_RST,
    seq: (SEQ_LEN*8)'(adc_cfg_pkg::SEQ_RST),
    seq_ptr: '0,
    hw_range: adc_cfg_pkg::RNG_REGS,
    settle_cnt: '0,
    settling: 1'b0,
    sel_a: '0,
    sel_b: '0,
    range_a: adc_cfg_pkg::RNG_10V,
    range_b: adc_cfg_pkg::RNG_10V,
    prdata: '0,
    pready: 1'b0,
    pslverr: 1'b0
  };

  ctrl_t st;
  ctrl_t next_st;
  logic sw_mode;
  logic cfg_ready;
  logic int_ref;
  logic [1:0] strap_code;
  logic setup_phase;
  logic access_done;
  logic addr_known;
  logic cfg_addr;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Maps a range code to the applied range; the register code means
  // the default range when nothing else selects one.
  function automatic logic [1:0] eff_range(input logic [1:0] code);
    eff_range = (code == adc_cfg_pkg::RNG_REGS) ?
      adc_cfg_pkg::RNG_10V : code;
  endfunction

  // Looks up the range field of one channel; diagnostics use the default.
  function automatic logic [1:0] chan_range(input logic [31:0] ranges,
                                            input logic bank_b,
                                            input logic [3:0] sel);
    logic [3:0] idx;
    idx = {bank_b, sel[2:0]};
    if (sel[3]) begin
      chan_range = adc_cfg_pkg::RNG_10V;
    end else begin
      chan_range = eff_range(ranges[{idx, 1'b0} +: 2]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Submodules.

  strap_latch u_strap (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .range_strap_lo_in(range_strap_lo_in),
    .range_strap_hi_in(range_strap_hi_in),
    .reference_source_pin_in(reference_source_pin_in),
    .sw_mode_out(sw_mode),
    .int_ref_en_out(int_ref),
    .cfg_ready_out(cfg_ready)
  );

  code_former u_former (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .sample_in(sample_in),
    .sample_valid_in(sample_valid_in),
    .result_out(result_out),
    .result_valid_out(result_valid_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Strap code and bus decode terms used by the register logic.
  assign strap_code = {range_strap_hi_in, range_strap_lo_in};
  assign setup_phase = psel_in && !penable_in;
  assign access_done = psel_in && penable_in && st.pready;
  assign cfg_addr = paddr_in == adc_cfg_pkg::OFS_CTRL ||
                    paddr_in == adc_cfg_pkg::OFS_RANGE ||
                    paddr_in == adc_cfg_pkg::OFS_SEQ0 ||
                    paddr_in == adc_cfg_pkg::OFS_SEQ1;
  assign addr_known = cfg_addr || paddr_in == adc_cfg_pkg::OFS_STATUS;

  // Computes the whole next state: bus, selection, ranges and settling.
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // The answer is prepared in the setup phase and stands one cycle.
    if (setup_phase) begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      next_st.pslverr = !addr_known ||
                        (pwrite_in && cfg_addr && !sw_mode);
      if (!pwrite_in) begin
        case (paddr_in)
          adc_cfg_pkg::OFS_CTRL: begin
            next_st.prdata[adc_cfg_pkg::CTRL_SEQ_EN_BIT] = st.seq_en;
            next_st.prdata[adc_cfg_pkg::CTRL_SEQ_LAST_LSB +: PTR_W] =
              st.seq_last;
            next_st.prdata[adc_cfg_pkg::CTRL_MAN_A_LSB +: 4] = st.man_a;
            next_st.prdata[adc_cfg_pkg::CTRL_MAN_B_LSB +: 4] = st.man_b;
          end
          adc_cfg_pkg::OFS_RANGE: next_st.prdata = st.ranges;
          adc_cfg_pkg::OFS_SEQ0: next_st.prdata = st.seq[31:0];
          adc_cfg_pkg::OFS_SEQ1: next_st.prdata = st.seq[63:32];
          adc_cfg_pkg::OFS_STATUS: begin
            next_st.prdata[adc_cfg_pkg::STAT_SW_MODE_BIT] = sw_mode;
            next_st.prdata[adc_cfg_pkg::STAT_INT_REF_BIT] = int_ref;
            next_st.prdata[adc_cfg_pkg::STAT_SETTLING_BIT] = st.settling;
            next_st.prdata[adc_cfg_pkg::STAT_CFG_READY_BIT] = cfg_ready;
            next_st.prdata[adc_cfg_pkg::STAT_HW_RANGE_LSB +: 2] =
              st.hw_range;
            next_st.prdata[adc_cfg_pkg::STAT_SEQ_PTR_LSB +: PTR_W] =
              st.seq_ptr;
            next_st.prdata[adc_cfg_pkg::STAT_SEL_A_LSB +: 4] = st.sel_a;
            next_st.prdata[adc_cfg_pkg::STAT_SEL_B_LSB +: 4] = st.sel_b;
          end
          default: next_st.prdata = '0;
        endcase
      end
    end

    if (access_done && pwrite_in && sw_mode && cfg_ready) begin
      case (paddr_in)
        adc_cfg_pkg::OFS_CTRL: begin
          next_st.seq_en = pwdata_in[adc_cfg_pkg::CTRL_SEQ_EN_BIT];
          next_st.seq_last =
            pwdata_in[adc_cfg_pkg::CTRL_SEQ_LAST_LSB +: PTR_W];
          next_st.man_a = pwdata_in[adc_cfg_pkg::CTRL_MAN_A_LSB +: 4];
          next_st.man_b = pwdata_in[adc_cfg_pkg::CTRL_MAN_B_LSB +: 4];
          next_st.seq_ptr = '0;
        end
        adc_cfg_pkg::OFS_RANGE: next_st.ranges = pwdata_in;
        adc_cfg_pkg::OFS_SEQ0: next_st.seq[31:0] = pwdata_in;
        adc_cfg_pkg::OFS_SEQ1: next_st.seq[63:32] = pwdata_in;
        default: next_st.seq_en = st.seq_en;
      endcase
    end

    if (cfg_ready && !sw_mode) begin
      if (conv_start_in) begin
        next_st.sel_a = {1'b0, pair_select_pins_in};
        next_st.sel_b = {1'b0, pair_select_pins_in};
      end
      if (strap_code != st.hw_range) begin
        next_st.hw_range = strap_code;
        next_st.settle_cnt = CNT_W'(SETTLE_CYCLES);
      end else if (st.settle_cnt != '0) begin
        next_st.settle_cnt = st.settle_cnt - 1'b1;
      end
      next_st.range_a = eff_range(strap_code);
      next_st.range_b = eff_range(strap_code);
    end else if (cfg_ready) begin
      if (conv_start_in && st.seq_en) begin
        next_st.sel_a = st.seq[{st.seq_ptr, 3'h0} +: 4];
        next_st.sel_b = st.seq[{st.seq_ptr, 3'h4} +: 4];
        next_st.seq_ptr = (st.seq_ptr == st.seq_last) ? '0 :
          PTR_W'(st.seq_ptr + 1'b1);
      end else if (conv_start_in) begin
        next_st.sel_a = st.man_a;
        next_st.sel_b = st.man_b;
      end
      next_st.range_a = chan_range(st.ranges, 1'b0, next_st.sel_a);
      next_st.range_b = chan_range(st.ranges, 1'b1, next_st.sel_b);
      next_st.settle_cnt = '0;
    end
    next_st.settling = next_st.settle_cnt != '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous reset returns every field to its documented default.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= CTRL_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from flip-flops here or in the submodules.
  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign sw_mode_out = sw_mode;
  assign int_ref_en_out = int_ref;
  assign cfg_ready_out = cfg_ready;
  assign conv_a_sel_out = st.sel_a;
  assign conv_b_sel_out = st.sel_b;
  assign range_a_out = st.range_a;
  assign range_b_out = st.range_b;
  assign settling_out = st.settling;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence apb_setup_s;
    psel_in && !penable_in;
  endsequence

  sequence apb_answer_s;
    pready_out ##1 !pready_out;
  endsequence

  sequence hw_strap_move_s;
    cfg_ready && !sw_mode && strap_code != st.hw_range;
  endsequence

  a_apb_answer: assert property (
    apb_setup_s |=> apb_answer_s)
    else $error("APB answer not one access cycle");
  a_hw_write_block: assert property (
    access_done && pwrite_in && cfg_addr && !sw_mode |->
      pslverr_out ##1 $stable(st.ranges) && $stable(st.seq))
    else $error("hardware mode accepted a register write");
  a_hw_pair_same: assert property (
    cfg_ready && !sw_mode && conv_start_in |=>
      conv_a_sel_out == conv_b_sel_out &&
      conv_a_sel_out == {1'b0, $past(pair_select_pins_in)})
    else $error("hardware pair not same index");
  a_no_diag_hw: assert property (
    cfg_ready && !sw_mode && conv_start_in |=>
      conv_a_sel_out < adc_cfg_pkg::DIAG_VCC)
    else $error("diagnostic channel chosen in hardware mode");
  a_hw_range_now: assert property (
    cfg_ready && !sw_mode && strap_code == adc_cfg_pkg::RNG_2V5 |=>
      range_a_out == adc_cfg_pkg::RNG_2V5 &&
      range_b_out == adc_cfg_pkg::RNG_2V5)
    else $error("strap range not applied next cycle");
  a_settle_window: assert property (
    hw_strap_move_s |=> settling_out [*8])
    else $error("settling not held after strap change");
  a_seq_wrap: assert property (
    cfg_ready && sw_mode && st.seq_en && conv_start_in &&
      st.seq_ptr == st.seq_last && !access_done |=> st.seq_ptr == '0)
    else $error("sequencer did not wrap at last entry");
  a_sw_range_pick: assert property (
    cfg_ready && sw_mode && conv_start_in && !st.seq_en &&
      st.man_a == 4'h0 && st.ranges[1:0] == adc_cfg_pkg::RNG_5V |=>
      range_a_out == adc_cfg_pkg::RNG_5V)
    else $error("channel range field not applied");
endmodule

// ===== rtl/adc_cfg_pkg.sv
// Constants shared by the converter configuration logic.
package adc_cfg_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RANGE = 8'h04;
  localparam logic [7:0] OFS_SEQ0 = 8'h08;
  localparam logic [7:0] OFS_SEQ1 = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Control register fields.
  localparam int CTRL_SEQ_EN_BIT = 0;
  localparam int CTRL_SEQ_LAST_LSB = 4;
  localparam int CTRL_MAN_A_LSB = 8;
  localparam int CTRL_MAN_B_LSB = 12;
  // Status register fields.
  localparam int STAT_SW_MODE_BIT = 0;
  localparam int STAT_INT_REF_BIT = 1;
  localparam int STAT_SETTLING_BIT = 2;
  localparam int STAT_CFG_READY_BIT = 3;
  localparam int STAT_HW_RANGE_LSB = 4;
  localparam int STAT_SEQ_PTR_LSB = 8;
  localparam int STAT_SEL_A_LSB = 16;
  localparam int STAT_SEL_B_LSB = 20;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RANGE_RST = 32'hFFFF_FFFF;
  localparam logic [63:0] SEQ_RST = 64'h0000_0000_0000_0000;
  // Input range codes, shared by strap pins and range fields.
  localparam logic [1:0] RNG_REGS = 2'h0;
  localparam logic [1:0] RNG_2V5 = 2'h1;
  localparam logic [1:0] RNG_5V = 2'h2;
  localparam logic [1:0] RNG_10V = 2'h3;
  // Channel select codes: 0 to 7 analog, then two diagnostics.
  localparam logic [3:0] DIAG_VCC = 4'h8;
  localparam logic [3:0] DIAG_LDO = 4'h9;
  // Range settling time after a strap change.
  localparam int SETTLE_US = 120;
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  // Conversion word and quarter-LSB input fraction.
  localparam int CODE_W = 16;
  localparam int FRAC_BITS = 2;
  localparam int SAMPLE_W = CODE_W + FRAC_BITS + 2;
endpackage

// ===== rtl/code_former.sv
// Rounds a fine sample to a saturated 16-bit twos-complement code.
module code_former #(
  parameter int SW = adc_cfg_pkg::SAMPLE_W
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic signed [SW-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic [adc_cfg_pkg::CODE_W-1:0] result_out,
  output logic result_valid_out
);
  localparam int CW = adc_cfg_pkg::CODE_W;
  localparam int FB = adc_cfg_pkg::FRAC_BITS;
  localparam logic signed [SW-1:0] HALF = SW'(1 << (FB - 1));
  localparam logic signed [SW-1:0] MAXV = SW'((1 << (CW - 1)) - 1);
  localparam logic signed [SW-1:0] MINV = -SW'(1 << (CW - 1));

  typedef struct packed {
    logic [CW-1:0] code;
    logic valid;
  } former_t;

  former_t st;
  former_t next_st;
  // One spare bit keeps the rounding carry from wrapping at full scale.
  logic signed [SW:0] rounded;

  always_comb begin
    rounded = ((SW+1)'(sample_in) + (SW+1)'(HALF)) >>> FB;
    next_st.valid = sample_valid_in;
    next_st.code = st.code;
    if (sample_valid_in) begin
      if (rounded > MAXV) begin
        next_st.code = MAXV[CW-1:0];
      end else if (rounded < MINV) begin
        next_st.code = MINV[CW-1:0];
      end else begin
        next_st.code = rounded[CW-1:0];
      end
    end
  end

  // Registers the code so the output comes from a flip-flop.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign result_out = st.code;
  assign result_valid_out = st.valid;

  a_code_round: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    sample_valid_in && sample_in == HALF |=> result_out == 16'h0001)
    else $error("half LSB does not round to code one");
endmodule

// ===== rtl/strap_latch.sv
// Capture of mode and reference straps at full-reset release.
module strap_latch (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic range_strap_lo_in,
  input wire logic range_strap_hi_in,
  input wire logic reference_source_pin_in,
  output logic sw_mode_out,
  output logic int_ref_en_out,
  output logic cfg_ready_out
);
  typedef struct packed {
    logic captured;
    logic sw_mode;
    logic int_ref;
  } strap_t;

  strap_t st;
  strap_t next_st;

  // Straps are sampled once, on the first edge after reset release.
  always_comb begin
    next_st = st;
    if (!st.captured) begin
      next_st.captured = 1'b1;
      next_st.sw_mode = !range_strap_lo_in && !range_strap_hi_in;
      next_st.int_ref = reference_source_pin_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sw_mode_out = st.sw_mode;
  assign int_ref_en_out = st.int_ref;
  assign cfg_ready_out = st.captured;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_mode_at_release: assert property (
    $rose(st.captured) |->
      st.sw_mode == ($past(range_strap_lo_in) == 1'b0 &&
                     $past(range_strap_hi_in) == 1'b0))
    else $error("mode does not follow straps at release");
  a_ref_held: assert property (
    $rose(st.captured) ##1 1'b1 |->
      $stable(st.int_ref) && $stable(st.sw_mode))
    else $error("latched straps changed before reset");
endmodule

// ===== sim/host_pins.sv
// Host-side model of the strap, pair-select and reset pins.
module host_pins (
  input wire logic mclk_in,
  input wire logic go_reset_in,
  input wire logic [1:0] strap_code_in,
  input wire logic ref_in,
  input wire logic [2:0] pair_in,
  output logic rst_n_out,
  output logic range_strap_lo_out,
  output logic range_strap_hi_out,
  output logic reference_source_pin_out,
  output logic [2:0] pair_select_pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rst_cnt = 8'h05;
  assign rst_n_out = (rst_cnt == 8'h00);
  // The first reset is short; later ones last 160 cycles, over 1.2 us.
  // full reset pulse
  always @(posedge mclk_in) begin
    if (go_reset_in)
      rst_cnt <= 8'hA0;
    else if (rst_cnt != 8'h00)
      rst_cnt <= rst_cnt - 8'h01;
  end
  // Straps change only when the host is told to, then stay put.
  // straps held steady
  always @(posedge mclk_in) begin
    {range_strap_hi_out, range_strap_lo_out} <= strap_code_in;
    reference_source_pin_out <= ref_in;
    pair_select_pins_out <= pair_in;
  end
endmodule

// ===== sim/tb.sv
// Self-checking bench of the converter configuration block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 16;
  logic mclk_in = 1'h0;
  logic rst_n_in, lo, hi, refp;
  logic [2:0] pins;
  logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, range_val;
  logic pready_out, pslverr_out, sw_mode_out, int_ref_en_out;
  logic cfg_ready_out, settling_out, result_valid_out;
  logic conv_start_in = 1'h0, sample_valid_in = 1'h0;
  logic signed [adc_cfg_pkg::SAMPLE_W-1:0] sample_in = '0;
  logic [3:0] conv_a_sel_out, conv_b_sel_out;
  logic [1:0] range_a_out, range_b_out, code = 2'h0;
  logic [adc_cfg_pkg::CODE_W-1:0] result_out;
  logic go_reset = 1'h0, ref_sel = 1'h1;
  logic [2:0] pair = 3'h0;
  int mismatches = 0, total_checks = 0, cycles = 0;
  logic [33:0] apb_q[$];
  logic [15:0] res_q[$];

  always #4 mclk_in = ~mclk_in;

  host_pins host (.mclk_in(mclk_in), .go_reset_in(go_reset),
    .strap_code_in(code), .ref_in(ref_sel), .pair_in(pair),
    .rst_n_out(rst_n_in), .range_strap_lo_out(lo),
    .range_strap_hi_out(hi), .reference_source_pin_out(refp),
    .pair_select_pins_out(pins));

  adc_cfg_ctrl #(.SETTLE_CYCLES(SETTLE), .SEQ_LEN(8)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .range_strap_lo_in(lo), .range_strap_hi_in(hi),
    .reference_source_pin_in(refp), .pair_select_pins_in(pins),
    .conv_start_in(conv_start_in), .sample_in(sample_in),
    .sample_valid_in(sample_valid_in), .sw_mode_out(sw_mode_out),
    .int_ref_en_out(int_ref_en_out), .cfg_ready_out(cfg_ready_out),
    .conv_a_sel_out(conv_a_sel_out), .conv_b_sel_out(conv_b_sel_out),
    .range_a_out(range_a_out), .range_b_out(range_b_out),
    .settling_out(settling_out), .result_out(result_out),
    .result_valid_out(result_valid_out));

  ////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Expected range of a channel: diagnostics and code 0 apply 10 V.
  function automatic logic [1:0] rng(input logic [31:0] r, input int b,
                                     input logic [3:0] c);
    logic [1:0] f;
    if (c > 4'h7)
      return 2'h3;
    f = r[b * 16 + c * 2 +: 2];
    return (f == 2'h0) ? 2'h3 : f;
  endfunction

  // Expected code: round quarter-LSB input at half steps, saturate.
  function automatic logic [15:0] code16(input logic signed [19:0] s);
    int v;
    v = (int'(s) + 2) >>> 2;
    if (v > 32767)
      v = 32767;
    if (v < -32768)
      v = -32768;
    return v[15:0];
  endfunction

  // One APB transfer; the expected answer is noted for the monitor.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err,
                     input logic [31:0] rd);
    @(posedge mclk_in);
    psel_in <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    apb_q.push_back({!wr, err, rd});
    @(posedge mclk_in);
    penable_in <= 1'h1;
    do @(posedge mclk_in); while (pready_out !== 1'h1);
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask

  // Starts a conversion and checks the pair and ranges latched for it.
  task automatic conv(input logic [3:0] ea, eb, input logic [1:0] ra, rb);
    @(posedge mclk_in);
    conv_start_in <= 1'h1;
    @(posedge mclk_in);
    conv_start_in <= 1'h0;
    #1;
    check("sel_a", conv_a_sel_out, ea);
    check("sel_b", conv_b_sel_out, eb);
    check("range_a", range_a_out, ra);
    check("range_b", range_b_out, rb);
  endtask

  // Full reset with the given straps, then waits for the capture.
  task automatic do_reset(input logic [1:0] c, input logic r);
    @(posedge mclk_in);
    code <= c;
    ref_sel <= r;
    go_reset <= 1'h1;
    @(posedge mclk_in);
    go_reset <= 1'h0;
    @(posedge mclk_in);
    do @(posedge mclk_in); while (cfg_ready_out !== 1'h1);
    repeat (30) @(posedge mclk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitors take the oldest note whenever an answer appears.
  always @(posedge mclk_in) begin
    logic [33:0] n;
    if (psel_in && penable_in && pready_out === 1'h1 && apb_q.size() > 0)
    begin
      n = apb_q.pop_front();
      check("pslverr", pslverr_out, n[32]);
      if (n[33])
        check("prdata", prdata_out, n[31:0]);
    end
    if (result_valid_out === 1'h1 && res_q.size() > 0)
      check("result", result_out, res_q.pop_front());
  end

  // A hang is cut short after a fixed number of cycles.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      end_sim();
    end
  end

  // Main sequence: software mode first, then the hardware strap codes.
  initial begin
    logic signed [19:0] s;
    logic [2:0] p;
    int n;
    void'($urandom(89));
    do @(posedge mclk_in); while (cfg_ready_out !== 1'h1);
    repeat (2) @(posedge mclk_in);
    #1;
    check("sw_mode", sw_mode_out, 1'h1);
    check("int_ref", int_ref_en_out, 1'h1);
    @(posedge mclk_in);
    ref_sel <= 1'h0;
    repeat (3) @(posedge mclk_in);
    #1;
    check("int_ref_kept", int_ref_en_out, 1'h1);
    range_val = $urandom();
    range_val[1:0] = 2'h2;
    apb(1'h1, adc_cfg_pkg::OFS_RANGE, range_val, 1'h0, 32'h0);
    apb(1'h0, adc_cfg_pkg::OFS_RANGE, 32'h0, 1'h0, range_val);
    apb(1'h1, adc_cfg_pkg::OFS_CTRL, 32'h0000_5000, 1'h0, 32'h0);
    conv(4'h0, 4'h5, rng(range_val, 0, 4'h0), rng(range_val, 1, 4'h5));
    apb(1'h1, adc_cfg_pkg::OFS_CTRL, 32'h0000_9800, 1'h0, 32'h0);
    conv(adc_cfg_pkg::DIAG_VCC, adc_cfg_pkg::DIAG_LDO, 2'h3, 2'h3);
    apb(1'h1, adc_cfg_pkg::OFS_SEQ0, 32'h0000_6173, 1'h0, 32'h0);
    apb(1'h1, adc_cfg_pkg::OFS_CTRL, 32'h0000_0011, 1'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      if (i == 1)
        conv(4'h1, 4'h6, rng(range_val, 0, 4'h1), rng(range_val, 1, 4'h6));
      else
        conv(4'h3, 4'h7, rng(range_val, 0, 4'h3), rng(range_val, 1, 4'h7));
    end
    apb(1'h0, 8'h20, 32'h0, 1'h1, 32'h0);
    apb(1'h1, adc_cfg_pkg::OFS_STATUS, $urandom(), 1'h0, 32'h0);
    // Back-to-back samples: rounding corners, then random values.
    for (int i = 0; i < 16; i++) begin
      s = 20'($urandom());
      if (i[0])
        s = s >>> 3;
      if (i < 4)
        s = (i == 0) ? 20'h00002 : (i == 1) ? 20'h00001 :
            (i == 2) ? 20'hFFFFE : 20'hFFFFD;
      @(posedge mclk_in);
      sample_valid_in <= 1'h1;
      sample_in <= s;
      res_q.push_back(code16(s));
    end
    @(posedge mclk_in);
    sample_valid_in <= 1'h0;
    for (int k = 3; k > 0; k--) begin
      do_reset(k[1:0], k[0]);
      check("hw_mode", sw_mode_out, 1'h0);
      check("hw_ref", int_ref_en_out, k[0]);
      check("hw_range", range_a_out, k[1:0]);
      p = 3'($urandom());
      @(posedge mclk_in);
      pair <= p;
      conv({1'h0, p}, {1'h0, p}, k[1:0], k[1:0]);
      apb(1'h0, adc_cfg_pkg::OFS_STATUS, 32'h0, 1'h0, {8'h00, 1'h0, p,
          1'h0, p, 8'h00, 2'h0, k[1:0], 1'h1, 1'h0, k[0], 1'h0});
      apb(1'h1, adc_cfg_pkg::OFS_CTRL, 32'h0000_0001, 1'h1, 32'h0);
    end
    // A strap change in hardware mode applies at once and settles.
    @(posedge mclk_in);
    code <= 2'h0;
    n = 0;
    repeat (40) begin
      @(posedge mclk_in);
      if (settling_out === 1'h1)
        n++;
    end
    check("settle_cycles", n, SETTLE);
    check("range_now", range_a_out, 2'h3);
    check("mode_kept", sw_mode_out, 1'h0);
    end_sim();
  end
endmodule
